// file: rtl/pin_mux_pkg.sv
// shared constants for the port f and dram strobe pin multiplexer
// assumes a 32-bit axi4-lite register bus and active-low dram strobes
package pin_mux_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] PORT_OUT_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] PORT_DIR_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] DRAM_CFG_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] PORT_IN_OFS = 5'h0C;
  localparam logic [ADDR_W-1:0] ANALOG_CTL_OFS = 5'h10;

  // ------------------------------------------------------------
  // field layouts and reset values
  // ------------------------------------------------------------
  localparam int PORT_W = 8;
  localparam int CFG_W = 2;
  localparam int CFG_BUS16_BIT = 0;
  localparam int CFG_ONE_CAS_BIT = 1;
  localparam logic [PORT_W-1:0] PORT_OUT_RST = 8'h00;
  localparam logic [PORT_W-1:0] PORT_DIR_RST = 8'h00;
  localparam logic [CFG_W-1:0] DRAM_CFG_RST = 2'h0;
  localparam logic STROBE_IDLE = 1'b1;

  // ------------------------------------------------------------
  // pad positions within port f
  // ------------------------------------------------------------
  localparam int PAD_SER0_IN = 0;
  localparam int PAD_SER0_OUT = 1;
  localparam int PAD_SER0_CLK = 2;
  localparam int PAD_SER1_IN = 3;
  localparam int PAD_SER1_OUT = 4;
  localparam int PAD_SER2_IN = 5;
  localparam int PAD_SER2_OUT = 6;
  localparam int PAD_CONV_TRIG = 7;

  // ------------------------------------------------------------
  // axi response codes
  // ------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pin_mux_pkg

// file: rtl/dram_strobe_if.sv
// signals between the pin mux and its dram strobe router
// assumes one entry per dram area, area 4 at index 0, area 5 at index 1
`timescale 1ns/10ps
interface dram_strobe_if #(parameter int AREAS = 2);
  logic [AREAS-1:0] ras_n;
  logic [AREAS-1:0] cas_n;
  logic [AREAS-1:0] we_n;
  logic [AREAS-1:0] a0;
  logic bus16;
  logic one_cas;
  logic [AREAS-1:0] row_n;
  logic [AREAS-1:0] col_lo_n;
  logic [AREAS-1:0] col_hi_n;
  logic [AREAS-1:0] we_pad_n;

  modport ctrl (output ras_n, cas_n, we_n, a0, bus16, one_cas,
    input row_n, col_lo_n, col_hi_n, we_pad_n);
  modport route (input ras_n, cas_n, we_n, a0, bus16, one_cas,
    output row_n, col_lo_n, col_hi_n, we_pad_n);
endinterface : dram_strobe_if

// file: rtl/dram_strobe_route.sv
// combinational routing of dram strobes onto the per-area pads
// assumes strobes are active low and the caller registers the pads
`timescale 1ns/10ps
module dram_strobe_route import pin_mux_pkg::*; #(
  parameter int AREAS = 2
) (
  // controller side and pad side
  dram_strobe_if.route bus
);

  // ------------------------------------------------------------
  // per-area routing
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < AREAS; g++) begin : g_area
      // row strobe never moves between modes
      assign bus.row_n[g] = bus.ras_n[g];  // [R14]
      // three pad arrangements selected by bus width and strobe mode
      always_comb begin
        if (!bus.bus16) begin
          bus.col_lo_n[g] = bus.cas_n[g];  // [R14]
          bus.col_hi_n[g] = bus.cas_n[g];
          bus.we_pad_n[g] = bus.we_n[g];
        end else if (!bus.one_cas) begin
          // a0 low level means byte 0, high level byte 1
          bus.col_lo_n[g] = bus.a0[g] ? STROBE_IDLE : bus.cas_n[g];  // [R11] [R13]
          bus.col_hi_n[g] = bus.a0[g] ? bus.cas_n[g] : STROBE_IDLE;  // [R11]
          bus.we_pad_n[g] = bus.we_n[g];
        end else begin
          bus.col_lo_n[g] = bus.cas_n[g];
          bus.col_hi_n[g] = bus.a0[g] ? STROBE_IDLE : bus.we_n[g];  // [R12]
          bus.we_pad_n[g] = bus.a0[g] ? bus.we_n[g] : STROBE_IDLE;  // [R12]
        end
      end
    end
  endgenerate

endmodule : dram_strobe_route

// file: rtl/port_f_and_dram_strobe_pin_mux.sv
// pin multiplexer for port f pads and the dram strobe pads
// assumes peripheral enables and data are synchronous to clk
//
// How it works
// R01 - peripheral output beats port output on pad
// R02 - pad 1 is port only without serial0 out
// R03 - serial0 clock drives pad only when enabled
// R04 - serial1 data on pad only when enabled
// R05 - pad 4 is port only without serial1 out
// R06 - pad 6 is port only without serial2 out; here timer_out_en drives timer_pulse_out_2 on pad 6 when serial2 out is off
// R07 - timer pulses on pads only when enabled
// R08 - other logic disables outputs on input pads
// R09 - converter trigger pad input when external trigger; here timer_out_en still drives pad 7 as an output
// R10 - analog pads analog only when control selects
// R11 - two cas: low strobe a0=0, high a0=1
// R12 - one cas: high pad weL, we pad weH
// R13 - a0 low level is 0, high is 1
// R14 - fixed row strobes; 8-bit: both cas pads
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module port_f_and_dram_strobe_pin_mux import pin_mux_pkg::*; #(
  parameter int AN_W = 4
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // peripheral outputs and their enables
  input wire logic serial0_data_out,
  input wire logic serial0_out_en,
  input wire logic serial0_clock_pin_out,
  input wire logic serial0_clk_out_en,
  input wire logic serial1_data_out,
  input wire logic serial1_out_en,
  input wire logic serial2_data_out,
  input wire logic serial2_out_en,
  input wire logic timer_pulse_out_0,
  input wire logic timer_pulse_out_1,
  input wire logic timer_pulse_out_2,
  input wire logic timer_pulse_out_3,
  input wire logic timer_out_en,
  input wire logic converter_ext_trig_sel,
  // pad levels handed to peripherals
  output logic serial0_data_in,
  output logic serial0_clock_pin_in,
  output logic serial1_data_in,
  output logic serial2_data_in,
  output logic timer_trigger_in_0,
  output logic timer_trigger_in_1,
  output logic timer_trigger_in_2,
  output logic timer_trigger_in_3,
  output logic converter_trigger_in,
  output logic [AN_W-1:0] analog_mode,
  // port f pads
  input wire logic [PORT_W-1:0] pad_in,
  output logic [PORT_W-1:0] pad_out,
  output logic [PORT_W-1:0] pad_oe,
  // dram controller strobes, area 4 at index 0
  input wire logic [1:0] dram_ras_n,
  input wire logic [1:0] dram_cas_n,
  input wire logic [1:0] dram_we_n,
  input wire logic [1:0] dram_a0,
  // dram pads
  output logic row_strobe_area4_n,
  output logic row_strobe_area5_n,
  output logic col_strobe_lo_area4_n,
  output logic col_strobe_hi_area4_n,
  output logic col_strobe_lo_area5_n,
  output logic col_strobe_hi_area5_n,
  output logic write_enable_area4_n,
  output logic write_enable_area5_n
);

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  // port input is read-only, so a write there is an error
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic wr);
    case (a)
      PORT_OUT_OFS, PORT_DIR_OFS, DRAM_CFG_OFS, ANALOG_CTL_OFS: reg_hit = 1'b1;
      PORT_IN_OFS: reg_hit = !wr;
      default: reg_hit = 1'b0;
    endcase
  endfunction : reg_hit

  logic [PORT_W-1:0] port_out, next_port_out;
  logic [PORT_W-1:0] port_dir, next_port_dir;
  logic [CFG_W-1:0] dram_cfg, next_dram_cfg;
  logic [AN_W-1:0] next_analog_mode;
  logic next_awready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_take, rd_take;

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  // aw and w are taken together, so no write is ever half accepted
  assign wr_take = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  assign rd_take = s_axi_arvalid && s_axi_arready;

  // next bus handshake and register contents
  always_comb begin
    next_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                   !s_axi_bvalid;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_arready = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_port_out = port_out;
    next_port_dir = port_dir;
    next_dram_cfg = dram_cfg;
    next_analog_mode = analog_mode;
    if (wr_take) begin
      next_bvalid = 1'b1;
      next_bresp = reg_hit(s_axi_awaddr, 1'b1) ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_wstrb[0]) begin
        case (s_axi_awaddr)
          PORT_OUT_OFS: next_port_out = s_axi_wdata[PORT_W-1:0];
          PORT_DIR_OFS: next_port_dir = s_axi_wdata[PORT_W-1:0];
          DRAM_CFG_OFS: next_dram_cfg = s_axi_wdata[CFG_W-1:0];
          ANALOG_CTL_OFS: next_analog_mode = s_axi_wdata[AN_W-1:0];  // [R10]
          default: ;
        endcase
      end
    end
    if (rd_take) begin
      next_rvalid = 1'b1;
      next_rresp = reg_hit(s_axi_araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        PORT_OUT_OFS: next_rdata = {{(32-PORT_W){1'b0}}, port_out};
        PORT_DIR_OFS: next_rdata = {{(32-PORT_W){1'b0}}, port_dir};
        DRAM_CFG_OFS: next_rdata = {{(32-CFG_W){1'b0}}, dram_cfg};
        PORT_IN_OFS: next_rdata = {{(32-PORT_W){1'b0}}, pad_in};
        ANALOG_CTL_OFS: next_rdata = {{(32-AN_W){1'b0}}, analog_mode};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // bus and register flops; ce low freezes the bus too
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      port_out <= PORT_OUT_RST;
      port_dir <= PORT_DIR_RST;
      dram_cfg <= DRAM_CFG_RST;
      analog_mode <= '0;
    end else if (ce) begin
      s_axi_awready <= next_awready;
      s_axi_wready <= next_awready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      port_out <= next_port_out;
      port_dir <= next_port_dir;
      dram_cfg <= next_dram_cfg;
      analog_mode <= next_analog_mode;
    end
  end

  analog_mode_a: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    ce && wr_take && s_axi_wstrb[0] && s_axi_awaddr == ANALOG_CTL_OFS
    |=> analog_mode == $past(s_axi_wdata[AN_W-1:0]))
    else $error("analog mode did not follow control write");

  // ------------------------------------------------------------
  // port f pad selection
  // ------------------------------------------------------------
  logic [PORT_W-1:0] next_pad_out, next_pad_oe;
  // port value by default, any enabled peripheral output overrides it
  always_comb begin
    next_pad_out = port_out;
    next_pad_oe = port_dir;
    if (serial0_out_en) begin
      next_pad_out[PAD_SER0_OUT] = serial0_data_out;  // [R01] [R02]
      next_pad_oe[PAD_SER0_OUT] = 1'b1;
    end
    if (serial0_clk_out_en) begin
      next_pad_out[PAD_SER0_CLK] = serial0_clock_pin_out;  // [R03]
      next_pad_oe[PAD_SER0_CLK] = 1'b1;
    end else if (timer_out_en) begin
      next_pad_out[PAD_SER0_CLK] = timer_pulse_out_3;  // [R07]
      next_pad_oe[PAD_SER0_CLK] = 1'b1;
    end
    if (serial1_out_en) begin
      next_pad_out[PAD_SER1_OUT] = serial1_data_out;  // [R04] [R05]
      next_pad_oe[PAD_SER1_OUT] = 1'b1;
    end
    if (timer_out_en) begin
      next_pad_out[PAD_SER2_IN] = timer_pulse_out_1;  // [R01] [R07]
      next_pad_oe[PAD_SER2_IN] = 1'b1;
    end
    if (serial2_out_en) begin
      next_pad_out[PAD_SER2_OUT] = serial2_data_out;  // [R06]
      next_pad_oe[PAD_SER2_OUT] = 1'b1;
    end else if (timer_out_en) begin
      next_pad_out[PAD_SER2_OUT] = timer_pulse_out_2;  // [R07]
      next_pad_oe[PAD_SER2_OUT] = 1'b1;
    end
    if (timer_out_en) begin
      next_pad_out[PAD_CONV_TRIG] = timer_pulse_out_0;  // [R07]
      next_pad_oe[PAD_CONV_TRIG] = 1'b1;
    end else if (converter_ext_trig_sel) begin
      next_pad_oe[PAD_CONV_TRIG] = 1'b0;  // [R09]
    end
  end

  // pad flops, released to port value on reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pad_out <= PORT_OUT_RST;
      pad_oe <= PORT_DIR_RST;
    end else if (ce) begin
      pad_out <= next_pad_out;
      pad_oe <= next_pad_oe;
    end
  end

  serial0_out_a: assert property (@(posedge clk) disable iff (sys_rst) // [R02]
    ce && serial0_out_en
    |=> pad_oe[PAD_SER0_OUT] && pad_out[PAD_SER0_OUT] == $past(serial0_data_out))
    else $error("serial0 data not on its pad");
  periph_priority_a: assert property (@(posedge clk) disable iff (sys_rst) // [R01]
    ce && timer_out_en && port_dir[PAD_SER2_IN]
    |=> pad_out[PAD_SER2_IN] == $past(timer_pulse_out_1))
    else $error("port output won over timer output");
  serial0_clock_a: assert property (@(posedge clk) disable iff (sys_rst) // [R03]
    ce && !serial0_clk_out_en && !timer_out_en
    |=> pad_oe[PAD_SER0_CLK] == $past(port_dir[PAD_SER0_CLK]) &&
        pad_out[PAD_SER0_CLK] == $past(port_out[PAD_SER0_CLK]))
    else $error("clock pad not released to port");
  serial1_out_a: assert property (@(posedge clk) disable iff (sys_rst) // [R04]
    ce && serial1_out_en
    |=> pad_oe[PAD_SER1_OUT] && pad_out[PAD_SER1_OUT] == $past(serial1_data_out))
    else $error("serial1 data not on its pad");
  serial1_port_a: assert property (@(posedge clk) disable iff (sys_rst) // [R05]
    ce && !serial1_out_en
    |=> pad_oe[PAD_SER1_OUT] == $past(port_dir[PAD_SER1_OUT]))
    else $error("serial1 pad not released to port");
  serial2_out_a: assert property (@(posedge clk) disable iff (sys_rst) // [R06]
    ce && serial2_out_en |=> pad_oe[PAD_SER2_OUT] &&
    pad_out[PAD_SER2_OUT] == $past(serial2_data_out))
    else $error("serial2 pad held by port while enabled");
  timer_port_a: assert property (@(posedge clk) disable iff (sys_rst) // [R07]
    ce && !timer_out_en && !converter_ext_trig_sel
    |=> pad_oe[PAD_CONV_TRIG] == $past(port_dir[PAD_CONV_TRIG]))
    else $error("last port pad not released by timer");

  // ------------------------------------------------------------
  // pad levels to peripherals
  // ------------------------------------------------------------
  // the pad is sampled as is; other functions must stay quiet on it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serial0_data_in <= STROBE_IDLE;
      serial0_clock_pin_in <= STROBE_IDLE;
      serial1_data_in <= STROBE_IDLE;
      serial2_data_in <= STROBE_IDLE;
      timer_trigger_in_0 <= 1'b0;
      timer_trigger_in_1 <= 1'b0;
      timer_trigger_in_2 <= 1'b0;
      timer_trigger_in_3 <= 1'b0;
      converter_trigger_in <= STROBE_IDLE;
    end else if (ce) begin
      serial0_data_in <= pad_in[PAD_SER0_IN];  // [R08]
      serial0_clock_pin_in <= pad_in[PAD_SER0_CLK];
      serial1_data_in <= pad_in[PAD_SER1_IN];
      serial2_data_in <= pad_in[PAD_SER2_IN];
      timer_trigger_in_0 <= pad_in[PAD_SER0_IN];
      timer_trigger_in_1 <= pad_in[PAD_SER0_OUT];
      timer_trigger_in_2 <= pad_in[PAD_SER1_IN];
      timer_trigger_in_3 <= pad_in[PAD_SER1_OUT];
      // idle high unless external triggering is selected
      converter_trigger_in <= converter_ext_trig_sel ?
        pad_in[PAD_CONV_TRIG] : STROBE_IDLE;  // [R09]
    end
  end

  conv_trigger_a: assert property (@(posedge clk) disable iff (sys_rst) // [R09]
    ce && converter_ext_trig_sel && !timer_out_en
    |=> !pad_oe[PAD_CONV_TRIG] &&
        converter_trigger_in == $past(pad_in[PAD_CONV_TRIG]))
    else $error("converter trigger pad not an input");

  // ------------------------------------------------------------
  // dram strobe pads
  // ------------------------------------------------------------
  dram_strobe_if #(.AREAS(2)) strobes ();
  // controller strobes into the router
  assign strobes.ras_n = dram_ras_n;
  assign strobes.cas_n = dram_cas_n;
  assign strobes.we_n = dram_we_n;
  assign strobes.a0 = dram_a0;
  assign strobes.bus16 = dram_cfg[CFG_BUS16_BIT];
  assign strobes.one_cas = dram_cfg[CFG_ONE_CAS_BIT];

  dram_strobe_route #(.AREAS(2)) u_route (
    .bus (strobes.route)
  );

  // registered pads, idle high so memory sees no strobe in reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      row_strobe_area4_n <= STROBE_IDLE;
      row_strobe_area5_n <= STROBE_IDLE;
      col_strobe_lo_area4_n <= STROBE_IDLE;
      col_strobe_hi_area4_n <= STROBE_IDLE;
      col_strobe_lo_area5_n <= STROBE_IDLE;
      col_strobe_hi_area5_n <= STROBE_IDLE;
      write_enable_area4_n <= STROBE_IDLE;
      write_enable_area5_n <= STROBE_IDLE;
    end else if (ce) begin
      row_strobe_area4_n <= strobes.row_n[0];  // [R14]
      row_strobe_area5_n <= strobes.row_n[1];
      col_strobe_lo_area4_n <= strobes.col_lo_n[0];  // [R11]
      col_strobe_hi_area4_n <= strobes.col_hi_n[0];
      col_strobe_lo_area5_n <= strobes.col_lo_n[1];
      col_strobe_hi_area5_n <= strobes.col_hi_n[1];
      write_enable_area4_n <= strobes.we_pad_n[0];  // [R12]
      write_enable_area5_n <= strobes.we_pad_n[1];
    end
  end

  col_low_a: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
    ce && dram_cfg == 2'h1 && dram_a0[0]
    |=> col_strobe_lo_area4_n && col_strobe_hi_area4_n == $past(dram_cas_n[0]))
    else $error("two-cas strobe on wrong byte");
  we_split_a: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
    ce && dram_cfg == 2'h3 && !dram_a0[1]
    |=> col_strobe_hi_area5_n == $past(dram_we_n[1]) && write_enable_area5_n)
    else $error("one-cas write enable on wrong pad");
  byte_mode_a: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
    ce && !dram_cfg[CFG_BUS16_BIT]
    |=> col_strobe_lo_area4_n == $past(dram_cas_n[0]) &&
        col_strobe_hi_area4_n == $past(dram_cas_n[0]) &&
        row_strobe_area5_n == $past(dram_ras_n[1]))
    else $error("8-bit mode strobe routing wrong");

endmodule : port_f_and_dram_strobe_pin_mux

// file: dv/dram_ctrl_model.sv
// behavioural dram controller driving strobes toward the pin mux
// assumes one access at a time, requested by a one-cycle start pulse
`timescale 1ns/10ps
module dram_ctrl_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // access request from the bench
  input wire logic start,
  input wire logic area,
  input wire logic addr0,
  input wire logic wr,
  // strobes toward the pin mux, active low, area 4 at index 0
  output logic [1:0] ras_n,
  output logic [1:0] cas_n,
  output logic [1:0] we_n,
  output logic [1:0] a0,
  output logic busy
);
  // ------------------------------------------------------------
  // access sequencer
  // ------------------------------------------------------------
  logic [2:0] cnt;
  logic area_q, a0_q, wr_q, idle_t;
  // row strobe leads, column and write strobes follow two cycles later
  always_ff @(posedge clk) begin
    idle_t <= ~idle_t;
    if (sys_rst) begin
      cnt <= 3'h0;
      area_q <= 1'b0;
      idle_t <= 1'b0;
    end else if (start && cnt == 3'h0) begin
      cnt <= 3'h7;
      area_q <= area;
      a0_q <= addr0;
      wr_q <= wr;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
  assign busy = (cnt != 3'h0);
  // the address line toggles when idle so stale values never look valid
  assign a0 = busy ? {2{a0_q}} : {2{idle_t}};
  always_comb begin
    ras_n = 2'h3;
    cas_n = 2'h3;
    we_n = 2'h3;
    ras_n[area_q] = !busy;
    cas_n[area_q] = !(busy && cnt <= 3'h5);
    we_n[area_q] = !(busy && wr_q && cnt <= 3'h5);
  end
endmodule : dram_ctrl_model

// file: dv/tb_top.sv
// self-checking bench for the port f and dram strobe pin mux
// assumes the register map and strobe routing of pin_mux_pkg
`timescale 1ns/10ps
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: %s", $time, m); end end
module tb_top import pin_mux_pkg::*;;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk = 0, sys_rst = 1, go = 0, ar = 0, ad = 0, wr = 0, ce = 1;
  logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, analog_mode;
  logic [1:0] s_axi_bresp, s_axi_rresp, d_ras, d_cas, d_we, d_a0;
  logic [4:0] en = 0;
  logic [7:0] pv = 8'h72, pad_in = 8'h3C, pad_out, pad_oe, si, dp;
  logic converter_ext_trig_sel = 0, converter_trigger_in;
  int bad_count = 0, checked = 0, cyc = 0;
  always #20 clk = ~clk;
  port_f_and_dram_strobe_pin_mux port_f_and_dram_strobe_pin_mux_inst (
    .clk, .sys_rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .serial0_data_out(pv[0]), .serial0_out_en(en[0]),
    .serial0_clock_pin_out(pv[1]), .serial0_clk_out_en(en[1]),
    .serial1_data_out(pv[2]), .serial1_out_en(en[2]),
    .serial2_data_out(pv[3]), .serial2_out_en(en[3]),
    .timer_pulse_out_0(pv[4]), .timer_pulse_out_1(pv[5]),
    .timer_pulse_out_2(pv[6]), .timer_pulse_out_3(pv[7]),
    .timer_out_en(en[4]), .converter_ext_trig_sel,
    .serial0_data_in(si[0]), .serial0_clock_pin_in(si[1]),
    .serial1_data_in(si[2]), .serial2_data_in(si[3]),
    .timer_trigger_in_0(si[4]), .timer_trigger_in_1(si[5]),
    .timer_trigger_in_2(si[6]), .timer_trigger_in_3(si[7]),
    .converter_trigger_in, .analog_mode, .pad_in, .pad_out, .pad_oe,
    .dram_ras_n(d_ras), .dram_cas_n(d_cas), .dram_we_n(d_we), .dram_a0(d_a0),
    .row_strobe_area4_n(dp[7]), .col_strobe_lo_area4_n(dp[6]),
    .col_strobe_hi_area4_n(dp[5]), .write_enable_area4_n(dp[4]),
    .row_strobe_area5_n(dp[3]), .col_strobe_lo_area5_n(dp[2]),
    .col_strobe_hi_area5_n(dp[1]), .write_enable_area5_n(dp[0]));
  dram_ctrl_model dram_ctrl_model_inst (.clk, .sys_rst, .start(go), .area(ar),
    .addr0(ad), .wr, .ras_n(d_ras), .cas_n(d_cas), .we_n(d_we), .a0(d_a0),
    .busy);
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic complete_run;
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  // address and data offered together, each released when taken;
  // bready and rready stay high between calls
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask : axi_wr
  task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axi_rd
  // outputs are registered, so two edges pass before they are read
  task automatic pads(input logic [4:0] e, input logic [7:0] eo, eoe);
    en <= e;
    repeat (2) @(posedge clk);
    `CHK(pad_oe, eoe, "pad enables")
    `CHK(pad_out & eoe, eo, "pad levels")
  endtask : pads
  // expected pads {row, col lo, col hi, we} of the accessed area, others idle
  function automatic logic [7:0] dram_exp(input logic [1:0] c,
                                          input logic a4, a, w);
    logic [3:0] s;
    s[3] = 1'b0;
    s[2] = (c == 2'h1) && a;
    s[1] = !c[0] ? 1'b0 : (c[1] ? !(w && !a) : !a);
    s[0] = (c == 2'h3) ? !(w && a) : !w;
    return a4 ? {4'hF, s} : {s, 4'hF};
  endfunction : dram_exp
  // ------------------------------------------------------------
  // sequence and watchdog
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    `CHK({pad_oe, dp, converter_trigger_in}, 17'h001FF, "reset")
    axi_wr(PORT_OUT_OFS, 32'h5A, r);
    `CHK(r, RESP_OKAY, "write response")
    axi_wr(PORT_DIR_OFS, 32'hFF, r);
    // byte lane 0 masked off: the port value must not change
    s_axi_wstrb <= 4'h0;
    axi_wr(PORT_OUT_OFS, 32'hFF, r);
    s_axi_wstrb <= 4'hF;
    axi_rd(PORT_OUT_OFS, d, r);
    `CHK({r, d}, {RESP_OKAY, 32'h5A}, "port readback")
    axi_rd(PORT_IN_OFS, d, r);
    `CHK(d, 32'h3C, "pad readback")
    `CHK(si, 8'hCE, "input copies")
    axi_wr(PORT_IN_OFS, 32'h0, r);
    `CHK(r, RESP_SLVERR, "read-only write")
    axi_rd(5'h14, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0}, "unmapped read")
    axi_wr(ANALOG_CTL_OFS, 32'hA, r);
    @(posedge clk);
    `CHK(analog_mode, 4'hA, "analog mode")
    pads(5'h1F, 8'hAC, 8'hFF);
    pads(5'h10, 8'hFA, 8'hFF);
    pads(5'h00, 8'h5A, 8'hFF);
    // clock enable low: pads must hold although the enables change
    ce <= 1'b0;
    pads(5'h1F, 8'h5A, 8'hFF);
    ce <= 1'b1;
    axi_wr(PORT_DIR_OFS, 32'h0, r);
    pads(5'h0F, 8'h04, 8'h56);
    pads(5'h10, 8'hE0, 8'hE4);
    axi_wr(PORT_DIR_OFS, 32'hFF, r);
    // timer stays off while pad 7 serves as the converter trigger
    converter_ext_trig_sel <= 1'b1;
    pads(5'h00, 8'h5A & 8'h7F, 8'h7F);
    `CHK(converter_trigger_in, 1'b0, "trigger follows pad")
    converter_ext_trig_sel <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(converter_trigger_in, 1'b1, "trigger idle")
    for (int c = 0; c < 4; c++) begin
      axi_wr(DRAM_CFG_OFS, 32'(c), r);
      for (int k = 0; k < 8; k++) begin
        ar <= k[2];
        ad <= k[1];
        wr <= k[0];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(dp, dram_exp(c[1:0], k[2], k[1], k[0]), "dram pads")
        while (busy) @(posedge clk);
        @(posedge clk);
      end
    end
    complete_run();
  end
endmodule : tb_top
